//--- rtl/io_map_pkg.sv
// constants for the servo line function mapper
//
// Summary of operation
// - each of the nine input lines takes its function from its own code register (lines 1-8, then 9).
// - software writes a function code per line; outputs 1-5 and output 6 each follow their own code register.
// - an input coded 0x25 raises the reverse torque limit, one coded 0x26 the forward torque limit.
// - inputs coded 0x43 and 0x44 form a two-bit selector of the gear numerator.
// - an output coded 0x04 is high while the motor is at its target speed.
// - an output coded 0x05 is high once the motor has reached its target position.
// - an output coded 0x10 is high as an early overload warning.
// - by default out1 is servo ready, out2 zero speed, out5 alarm, out4 target position or brake.
`default_nettype none
package io_map_pkg;
    localparam int n_in = 9;
    localparam int n_out = 6;
    // function codes, inputs
    localparam logic [7:0] di_rev_tq = 8'h25;
    localparam logic [7:0] di_fwd_tq = 8'h26;
    localparam logic [7:0] di_gear0 = 8'h43;
    localparam logic [7:0] di_gear1 = 8'h44;
    // function codes, outputs
    localparam logic [7:0] do_ready = 8'h01;
    localparam logic [7:0] do_zero = 8'h03;
    localparam logic [7:0] do_speed = 8'h04;
    localparam logic [7:0] do_pos = 8'h05;
    localparam logic [7:0] do_alarm = 8'h07;
    localparam logic [7:0] do_brake = 8'h08;
    localparam logic [7:0] do_olw = 8'h10;
    // register byte offsets
    localparam logic [7:0] off_di_base = 8'h00; // input codes 1..9 at 0x00..0x20
    localparam logic [7:0] off_do_base = 8'h40; // output codes 1..6 at 0x40..0x54
    localparam logic [7:0] off_mode = 8'h80;
    localparam logic [7:0] off_status = 8'h84;
    // reset values
    localparam logic [7:0] rst_di_code = 8'h00;
    localparam logic [7:0] rst_do_code_0 = 8'h01;
    localparam logic [7:0] rst_do_code_1 = 8'h03;
    localparam logic [7:0] rst_do_code_2 = 8'h04;
    localparam logic [7:0] rst_do_code_3 = 8'h05;
    localparam logic [7:0] rst_do_code_4 = 8'h07;
    localparam logic [7:0] rst_do_code_5 = 8'h00;
    localparam logic rst_pos_mode = 1'b1;
endpackage : io_map_pkg
`default_nettype wire

//--- rtl/pin_sync.sv
// three-stage synchroniser with agreement filter for a bank of pins
`default_nettype none
module pin_sync #(
    parameter int width = 9
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [width-1:0] pin,
    output logic [width-1:0] level
);
    typedef struct packed {
        logic [width-1:0] s1;
        logic [width-1:0] s2;
        logic [width-1:0] s3;
        logic [width-1:0] lvl;
    } sync_state_t;
    sync_state_t state_reg;
    sync_state_t state_next;

    // shift, and accept a change once stages two and three agree
    always_comb begin
        state_next = state_reg;
        state_next.s1 = pin;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        for (int i = 0; i < width; i++) begin
            if (state_reg.s2[i] == state_reg.s3[i]) begin
                state_next.lvl[i] = state_reg.s3[i];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign level = state_reg.lvl;
endmodule : pin_sync
`default_nettype wire

//--- rtl/servo_io_function_mapper.sv
// line function mapper with its code registers on an ahb-lite slave
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`default_nettype none
module servo_io_function_mapper (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [8:0] di_pin,
    input wire logic servo_ready,
    input wire logic zero_speed,
    input wire logic speed_reached,
    input wire logic position_reached,
    input wire logic overload_warn,
    input wire logic alarm,
    input wire logic brake_release,
    output logic [5:0] do_pin,
    output logic rev_torque_limit_in,
    output logic fwd_torque_limit_in,
    output logic gear_num_sel0,
    output logic gear_num_sel1
);
    typedef struct packed {
        logic [8:0][7:0] di_code;
        logic [5:0][7:0] do_code;
        logic pos_mode;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic [5:0] dout;
        logic rev_tq;
        logic fwd_tq;
        logic g0;
        logic g1;
    } map_state_t;
    map_state_t state_reg;
    map_state_t state_next;

    logic [8:0] di_lvl;
    logic [5:0] do_src;
    logic [5:0] do_hit;
    logic [8:0] hit_rev;
    logic [8:0] hit_fwd;
    logic [8:0] hit_g0;
    logic [8:0] hit_g1;
    logic addr_phase;
    logic [7:0] a;

    // input pins cross into hclk
    pin_sync #(.width(9)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin(di_pin),
        .level(di_lvl)
    );

    // per input line: decode its code against the mapped functions
    genvar gi;
    generate
        for (gi = 0; gi < 9; gi++) begin : g_in
            assign hit_rev[gi] = di_lvl[gi] && state_reg.di_code[gi] == io_map_pkg::di_rev_tq;
            assign hit_fwd[gi] = di_lvl[gi] && state_reg.di_code[gi] == io_map_pkg::di_fwd_tq;
            assign hit_g0[gi] = di_lvl[gi] && state_reg.di_code[gi] == io_map_pkg::di_gear0;
            assign hit_g1[gi] = di_lvl[gi] && state_reg.di_code[gi] == io_map_pkg::di_gear1;
        end
    endgenerate

    // per output line: select the status named by its code
    genvar go;
    generate
        for (go = 0; go < 6; go++) begin : g_out
            logic src;
            logic hit;
            always_comb begin
                hit = 1'b1;
                unique case (state_reg.do_code[go])
                    io_map_pkg::do_ready: src = servo_ready;
                    io_map_pkg::do_zero: src = zero_speed;
                    io_map_pkg::do_speed: src = speed_reached;
                    io_map_pkg::do_pos: src = position_reached;
                    io_map_pkg::do_alarm: src = alarm;
                    io_map_pkg::do_brake: src = brake_release;
                    io_map_pkg::do_olw: src = overload_warn;
                    default: begin
                        src = 1'b0;
                        hit = 1'b0;
                    end
                endcase
            end
            assign do_src[go] = src;
            assign do_hit[go] = hit;
            // an unlisted code keeps its line low
            a_unlisted_low: assert property (@(posedge hclk) disable iff (!hresetn)
                !hit |=> !do_pin[go])
                else $error("unlisted code drives an output");
        end
    endgenerate

    assign addr_phase = hsel && hready && htrans[1];
    assign a = haddr[7:0];

    // register writes, read data capture, line outputs
    always_comb begin
        state_next = state_reg;
        state_next.wr_pend = 1'b0;
        // data phase of a pending write
        if (state_reg.wr_pend) begin
            for (int i = 0; i < 9; i++) begin
                if (state_reg.wr_addr == io_map_pkg::off_di_base + 8'(4 * i)) begin
                    state_next.di_code[i] = hwdata[7:0];
                end
            end
            for (int i = 0; i < 6; i++) begin
                if (state_reg.wr_addr == io_map_pkg::off_do_base + 8'(4 * i)) begin
                    state_next.do_code[i] = hwdata[7:0];
                end
            end
            if (state_reg.wr_addr == io_map_pkg::off_mode) begin
                state_next.pos_mode = hwdata[0];
                // out4 default follows the mode when left at a default code
                if (state_reg.do_code[3] == io_map_pkg::do_pos
                        || state_reg.do_code[3] == io_map_pkg::do_brake) begin
                    state_next.do_code[3] = hwdata[0] ? io_map_pkg::do_pos
                        : io_map_pkg::do_brake;
                end
            end
        end
        // address phase
        if (addr_phase) begin
            state_next.wr_pend = hwrite;
            state_next.wr_addr = {a[7:2], 2'b00};
            state_next.rdata = '0;
            if (!hwrite) begin
                for (int i = 0; i < 9; i++) begin
                    if ({a[7:2], 2'b00} == io_map_pkg::off_di_base + 8'(4 * i)) begin
                        state_next.rdata = {24'h000000, state_reg.di_code[i]};
                    end
                end
                for (int i = 0; i < 6; i++) begin
                    if ({a[7:2], 2'b00} == io_map_pkg::off_do_base + 8'(4 * i)) begin
                        state_next.rdata = {24'h000000, state_reg.do_code[i]};
                    end
                end
                if ({a[7:2], 2'b00} == io_map_pkg::off_mode) begin
                    state_next.rdata = {31'h00000000, state_reg.pos_mode};
                end
                if ({a[7:2], 2'b00} == io_map_pkg::off_status) begin
                    state_next.rdata = {4'h0, state_reg.g1, state_reg.g0,
                        state_reg.fwd_tq, state_reg.rev_tq, 2'h0, do_hit,
                        state_reg.dout, 1'b0, di_lvl};
                end
            end
        end
        // functional outputs, registered
        state_next.rev_tq = |hit_rev;
        state_next.fwd_tq = |hit_fwd;
        state_next.g0 = |hit_g0;
        state_next.g1 = |hit_g1;
        state_next.dout = do_src & do_hit;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= '0;
            state_reg.pos_mode <= io_map_pkg::rst_pos_mode;
            for (int i = 0; i < 9; i++) begin
                state_reg.di_code[i] <= io_map_pkg::rst_di_code;
            end
            state_reg.do_code[0] <= io_map_pkg::rst_do_code_0;
            state_reg.do_code[1] <= io_map_pkg::rst_do_code_1;
            state_reg.do_code[2] <= io_map_pkg::rst_do_code_2;
            state_reg.do_code[3] <= io_map_pkg::rst_do_code_3;
            state_reg.do_code[4] <= io_map_pkg::rst_do_code_4;
            state_reg.do_code[5] <= io_map_pkg::rst_do_code_5;
        end else begin
            state_reg <= state_next;
        end
    end

    assign hrdata = state_reg.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign do_pin = state_reg.dout;
    assign rev_torque_limit_in = state_reg.rev_tq;
    assign fwd_torque_limit_in = state_reg.fwd_tq;
    assign gear_num_sel0 = state_reg.g0;
    assign gear_num_sel1 = state_reg.g1;

    // out1 follows servo ready one cycle later under its reset code
    a_ready_default: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg.do_code[0] == io_map_pkg::do_ready |=> do_pin[0] == $past(servo_ready))
        else $error("out1 does not follow servo ready");
    a_alarm_out: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg.do_code[4] == io_map_pkg::do_alarm |=> do_pin[4] == $past(alarm))
        else $error("out5 does not follow alarm");
    a_speed_out: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_reg.do_code[2] == io_map_pkg::do_speed && speed_reached) |=> do_pin[2])
        else $error("speed reached not shown");
    a_pos_out: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_reg.do_code[3] == io_map_pkg::do_pos) |=> do_pin[3] == $past(position_reached))
        else $error("position reached not shown");
    a_olw_out: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_reg.do_code[5] == io_map_pkg::do_olw) |=> do_pin[5] == $past(overload_warn))
        else $error("overload warning not shown");
    a_bad_code_low: assert property (@(posedge hclk) disable iff (!hresetn)
        !do_hit[5] |=> !do_pin[5])
        else $error("unlisted code drives output");
    a_rev_limit: assert property (@(posedge hclk) disable iff (!hresetn)
        (|hit_rev) |=> rev_torque_limit_in)
        else $error("reverse torque limit missed");
    a_fwd_limit: assert property (@(posedge hclk) disable iff (!hresetn)
        fwd_torque_limit_in |-> $past(|hit_fwd))
        else $error("forward torque limit without cause");
    a_gear_sel: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 {gear_num_sel1, gear_num_sel0} == $past({|hit_g1, |hit_g0}))
        else $error("gear selector wrong");
    a_code_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_reg.wr_pend && state_reg.wr_addr == io_map_pkg::off_di_base)
        |=> state_reg.di_code[0] == $past(hwdata[7:0]))
        else $error("input code write lost");

    // a register write: address phase, then its data phase one cycle later
    sequence s_reg_wr(logic [7:0] word_off);
        addr_phase && hwrite && {a[7:2], 2'b00} == word_off
        ##1 state_reg.wr_pend && state_reg.wr_addr == word_off;
    endsequence
    // a register read: the address phase that captures the word
    sequence s_reg_rd(logic [7:0] word_off);
        addr_phase && !hwrite && {a[7:2], 2'b00} == word_off;
    endsequence

    // code writes land in the addressed line's register
    a_out6_write: assert property (@(posedge hclk) disable iff (!hresetn)
        s_reg_wr(io_map_pkg::off_do_base + 8'h14)
        |=> state_reg.do_code[5] == $past(hwdata[7:0]))
        else $error("output 6 code write lost");
    a_in9_write: assert property (@(posedge hclk) disable iff (!hresetn)
        s_reg_wr(io_map_pkg::off_di_base + 8'h20)
        |=> state_reg.di_code[8] == $past(hwdata[7:0]))
        else $error("input 9 code write lost");

    // mode write swaps out4 only between its two default codes
    a_mode_swap: assert property (@(posedge hclk) disable iff (!hresetn)
        s_reg_wr(io_map_pkg::off_mode) ##0 (state_reg.do_code[3] == io_map_pkg::do_pos
            || state_reg.do_code[3] == io_map_pkg::do_brake)
        |=> state_reg.do_code[3] == ($past(hwdata[0]) ? io_map_pkg::do_pos : io_map_pkg::do_brake))
        else $error("out4 default does not follow the mode");
    a_mode_other: assert property (@(posedge hclk) disable iff (!hresetn)
        s_reg_wr(io_map_pkg::off_mode) ##0 (state_reg.do_code[3] != io_map_pkg::do_pos
            && state_reg.do_code[3] != io_map_pkg::do_brake)
        |=> $stable(state_reg.do_code[3]))
        else $error("mode write moved a software code on out4");

    // default output functions and their release
    a_zero_default: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg.do_code[1] == io_map_pkg::do_zero |=> do_pin[1] == $past(zero_speed))
        else $error("out2 does not follow zero speed");
    a_brake_out: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg.do_code[3] == io_map_pkg::do_brake |=> do_pin[3] == $past(brake_release))
        else $error("out4 does not follow brake release");
    a_speed_drop: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_reg.do_code[2] == io_map_pkg::do_speed && !speed_reached) |=> !do_pin[2])
        else $error("speed reached shown without cause");

    // input functions need a line that holds their code
    a_rev_cause: assert property (@(posedge hclk) disable iff (!hresetn)
        rev_torque_limit_in |-> $past(|hit_rev))
        else $error("reverse torque limit without cause");
    a_fwd_set: assert property (@(posedge hclk) disable iff (!hresetn)
        (|hit_fwd) |=> fwd_torque_limit_in)
        else $error("forward torque limit missed");
    a_gear_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        !(|hit_g0) && !(|hit_g1) |=> !gear_num_sel0 && !gear_num_sel1)
        else $error("gear selector set without cause");

    // bus side: zero wait states, okay response, read data held
    a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_phase |-> hreadyout && !hresp)
        else $error("bus transfer not answered at once");
    a_data_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !addr_phase |=> $stable(hrdata))
        else $error("read data moved without a transfer");
    a_in9_read: assert property (@(posedge hclk) disable iff (!hresetn)
        s_reg_rd(io_map_pkg::off_di_base + 8'h20)
        |=> hrdata == {24'h000000, $past(state_reg.di_code[8])})
        else $error("input 9 code read wrong");
    a_mode_read: assert property (@(posedge hclk) disable iff (!hresetn)
        s_reg_rd(io_map_pkg::off_mode)
        |=> hrdata == {31'h00000000, $past(state_reg.pos_mode)})
        else $error("mode read wrong");
    a_status_read: assert property (@(posedge hclk) disable iff (!hresetn)
        s_reg_rd(io_map_pkg::off_status)
        |=> hrdata[21:10] == {$past(do_hit), $past(do_pin)})
        else $error("status does not show the output lines");
endmodule : servo_io_function_mapper
`default_nettype wire

//--- verif/line_driver.sv
// discrete-line driver standing in for the external controller
`default_nettype none
module line_driver (
    input wire logic hclk,
    input wire logic [8:0] want,
    output var logic [8:0] di_pin = 9'h000
);
    timeunit 1ns;
    timeprecision 1ns;
    // lines move once per clock at most, far below either pulse ceiling
    always @(posedge hclk) begin
        di_pin <= want;
    end
endmodule : line_driver
`default_nettype wire

//--- verif/servo_io_function_mapper_bench.sv
// self-checking bench for the line function mapper
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module servo_io_function_mapper_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [8:0] want = 9'h0;
    logic [8:0] di_pin;
    logic [6:0] st = 7'h0; // brake, alarm, overload, pos, speed, zero, ready
    logic [5:0] do_pin;
    logic rev, fwd, g0, g1;
    logic [9:0] obs;
    int fail_count = 0;
    int tests_run = 0;
    assign obs = {g1, g0, fwd, rev, do_pin};
    // clock of 100 ns period
    always #50 hclk = ~hclk;
    line_driver line_driver_i (.hclk(hclk), .want(want), .di_pin(di_pin));
    servo_io_function_mapper servo_io_function_mapper_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .di_pin(di_pin),
        .servo_ready(st[0]), .zero_speed(st[1]), .speed_reached(st[2]),
        .position_reached(st[3]), .overload_warn(st[4]), .alarm(st[5]),
        .brake_release(st[6]), .do_pin(do_pin), .rev_torque_limit_in(rev),
        .fwd_torque_limit_in(fwd), .gear_num_sel0(g0), .gear_num_sel1(g1)
    );
    // counts and verdict, then stop
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    task automatic give_up();
        fail_count++;
        $display("ERROR %0t: wait bound used up", $time);
        print_verdict();
    endtask : give_up
    // one bus phase: hold until hready sampled high
    task automatic wait_ready();
        int n;
        for (n = 0; n < 20; n++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) break;
        end
        if (n == 20) give_up();
    endtask : wait_ready
    // single word transfer, address phase then data phase
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        r = hrdata;
        `CHK(hresp, 1'b0)
    endtask : bus
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        `CHK(r, e)
    endtask : rd_chk
    // wait for the masked lines to match, then confirm they stay there
    task automatic expect_obs(input logic [9:0] mask, input logic [9:0] e);
        int n;
        for (n = 0; n < 12; n++) begin
            @(posedge hclk);
            if ((obs & mask) === e) break;
        end
        if (n == 12) give_up();
        repeat (6) @(posedge hclk);
        `CHK(obs & mask, e)
    endtask : expect_obs
    task automatic t_reset();
        logic [7:0] dflt [6] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h07, 8'h00};
        for (int i = 0; i < 6; i++) rd_chk(32'(32'h40 + 4 * i), {24'h0, dflt[i]});
        for (int i = 0; i < 9; i++) rd_chk(32'(4 * i), 32'h0);
        rd_chk(32'h80, 32'h1);
        wr(32'h60, 32'hff);
        rd_chk(32'h60, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_inputs();
        logic [8:0] pat [6] = '{9'h100, 9'h001, 9'h004, 9'h008, 9'h00c, 9'h002};
        logic [3:0] res [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hc, 4'h0};
        wr(32'h00, 32'h26);
        wr(32'h04, 32'h27);
        wr(32'h08, 32'h43);
        wr(32'h0c, 32'h44);
        wr(32'h20, 32'h25);
        rd_chk(32'h20, 32'h25);
        for (int i = 0; i < 6; i++) begin
            want <= pat[i];
            expect_obs(10'h3c0, {res[i], 6'h0});
            if (i == 4) rd_chk(32'h84, 32'h0c1f000c);
        end
        $display("test inputs done");
    endtask : t_inputs
    task automatic t_defaults();
        st <= 7'b1110101;
        expect_obs(10'h03f, 10'h015);
        rd_chk(32'h84, 32'h001f5402);
        wr(32'h80, 32'h0);
        rd_chk(32'h4c, 32'h08);
        expect_obs(10'h03f, 10'h01d);
        wr(32'h80, 32'h1);
        rd_chk(32'h4c, 32'h05);
        wr(32'h4c, 32'h10);
        wr(32'h80, 32'h0);
        rd_chk(32'h4c, 32'h10);
        wr(32'h80, 32'h1);
        wr(32'h4c, 32'h05);
        $display("test defaults done");
    endtask : t_defaults
    // line 6 follows only its coded source
    task automatic out_code(input logic [7:0] code, input logic [6:0] src, input logic on);
        wr(32'h54, {24'h0, code});
        st <= src;
        expect_obs(10'h020, {4'h0, on, 5'h0});
        st <= ~src;
        expect_obs(10'h020, 10'h0);
    endtask : out_code
    task automatic t_outputs();
        out_code(8'h04, 7'h04, 1'b1);
        out_code(8'h05, 7'h08, 1'b1);
        out_code(8'h10, 7'h10, 1'b1);
        out_code(8'h02, 7'h7f, 1'b0);
        rd_chk(32'h54, 32'h02);
        $display("test outputs done");
    endtask : t_outputs
    // reset, then the scenarios in turn
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_inputs();
        t_defaults();
        t_outputs();
        print_verdict();
    end
endmodule : servo_io_function_mapper_bench
`default_nettype wire
